// [core/xcvr_ctrl_defs.vh]
// constants for the transceiver mode controller and serial slave
`ifndef XCVR_CTRL_DEFS_VH
`define XCVR_CTRL_DEFS_VH

// clock rate and times
`define CLK_MHZ          125
`define OFF_MIN_MS       10
`define OFF_MAX_MS       25
`define HIB_MIN_MS       7
`define HIB_MAX_MS       20
`define DOZE_US          300
`define RXTX_US          144
`define OFF_CYCLES       (`OFF_MIN_MS * 1000 * `CLK_MHZ)
`define HIB_CYCLES       (`HIB_MIN_MS * 1000 * `CLK_MHZ)
`define DOZE_CYCLES      (`DOZE_US * `CLK_MHZ)
`define RXTX_CYCLES      (`RXTX_US * `CLK_MHZ)

// modes
`define MODE_OFF         3'h0
`define MODE_HIB         3'h1
`define MODE_DOZE        3'h2
`define MODE_IDLE        3'h3
`define MODE_RX          3'h4
`define MODE_TX          3'h5

// header: bit 7 read, bits 5:0 address
`define HDR_READ_BIT     7
`define ADDR_W           6

// internal register addresses
`define ADDR_MODE        6'h01
`define ADDR_CLOCK_OUTPUT_PIN        6'h07
`define ADDR_TIMER       6'h08
`define ADDR_POWER       6'h0c
`define ADDR_STATUS      6'h10

// mode command codes in mode register bits 2:0
`define CMD_HIB          3'h1
`define CMD_DOZE         3'h2
`define CMD_RX           3'h4
`define CMD_TX           3'h5
`define CMD_IDLE         3'h3

// clock output register fields
`define CLOCK_OUTPUT_PIN_EN_BIT      9
`define CLOCK_OUTPUT_PIN_SEL_LSB     0
`define CLOCK_OUTPUT_PIN_SEL_1MHZ    3'h3
`define CLOCK_OUTPUT_PIN_RST         16'h0005

// power register
`define POWER_NOMINAL    16'h00bc
`define POWER_MAX        16'h00ff
`define POWER_RST        16'h00bc

`endif

// [core/word_buffer.v]
// two-entry valid/ready buffer
`timescale 1ns/1ps
module word_buffer #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             mclk,
    input  wire             rst,
    // filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:1];
reg             wr_ptr;
reg             rd_ptr;
reg [1:0]       count;

wire push = in_valid && in_ready;
wire pop  = out_valid && out_ready;

assign in_ready  = (count != 2'h2);
assign out_valid = (count != 2'h0);
assign out_data  = mem[rd_ptr];

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        wr_ptr <= 1'b0;
        rd_ptr <= 1'b0;
        count  <= 2'h0;
    end else begin
        if (push)
            wr_ptr <= ~wr_ptr;
        if (pop)
            rd_ptr <= ~rd_ptr;
        if (push && !pop)
            count <= count + 2'h1;
        else if (pop && !push)
            count <= count - 2'h1;
    end
end

always @(posedge mclk) begin
    if (push)
        mem[wr_ptr] <= in_data;
end

endmodule // word_buffer

// [core/xcvr_ctrl.v]
// mode controller and serial slave port of the transceiver
`timescale 1ns/1ps
`include "xcvr_ctrl_defs.vh"
module xcvr_ctrl #(
    parameter OFF_CYCLES  = `OFF_CYCLES,
    parameter HIB_CYCLES  = `HIB_CYCLES,
    parameter DOZE_CYCLES = `DOZE_CYCLES,
    parameter RXTX_CYCLES = `RXTX_CYCLES
) (
    // core clock and reset
    input  wire        mclk,
    input  wire        rst,
    // device pins
    input  wire        reset_pin_n,
    input  wire        wake_request_n,
    // serial port
    input  wire        serial_clock_in,
    input  wire        chip_enable_n,
    input  wire        mosi,
    output reg         miso,
    output reg         miso_oe,
    // clock output pin
    output reg         clock_output_pin,
    output reg         clock_output_oe,
    // host interrupt line, open drain
    output reg         irq_n_out,
    output reg         irq_oe,
    // radio controls
    output reg         osc_on,
    output reg         rx_on,
    output reg         tx_on,
    output reg  [15:0] tx_power,
    output reg  [2:0]  mode
);

////////////////////////////////////////////////////////////////////////////
// pin synchronisers
// edges are found on the core clock: link half period must exceed 4 cycles

reg [1:0] rst_pin_s;
reg [1:0] wake_s;
reg [1:0] sck_s;
reg [1:0] ce_s;
reg [1:0] mosi_s;
reg       sck_d;

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        rst_pin_s <= 2'h0;
        wake_s    <= 2'h3;
        sck_s     <= 2'h0;
        ce_s      <= 2'h3;
        mosi_s    <= 2'h0;
        sck_d     <= 1'b0;
    end else begin
        rst_pin_s <= {rst_pin_s[0], reset_pin_n};
        wake_s    <= {wake_s[0], wake_request_n};
        sck_s     <= {sck_s[0], serial_clock_in};
        ce_s      <= {ce_s[0], chip_enable_n};
        mosi_s    <= {mosi_s[0], mosi};
        sck_d     <= sck_s[1];
    end
end

wire held_in_reset = !rst_pin_s[1];
wire ce_high       = ce_s[1];
wire sck_rise      = sck_s[1] && !sck_d;
wire sck_fall      = !sck_s[1] && sck_d;
wire wake_now      = !wake_s[1];

////////////////////////////////////////////////////////////////////////////
// serial slave shift logic

reg  [2:0]  bit_cnt;
reg  [7:0]  byte_cnt;
reg  [7:0]  shift_in;
reg  [7:0]  shift_out;
reg  [7:0]  header;
reg  [7:0]  data_hi;
reg  [15:0] rd_word;
wire        port_live = (mode == `MODE_IDLE) || (mode == `MODE_RX) ||
                        (mode == `MODE_TX);
wire        is_read   = header[`HDR_READ_BIT];
wire [7:0]  next_shift_in = {shift_in[6:0], mosi_s[1]};
wire        byte_done = sck_rise && (bit_cnt == 3'h7);
reg         wr_valid;
reg  [21:0] wr_data;
wire        wr_ready;

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        bit_cnt   <= 3'h0;
        byte_cnt  <= 8'h00;
        shift_in  <= 8'h00;
        shift_out <= 8'h00;
        header    <= 8'h00;
        data_hi   <= 8'h00;
        wr_valid  <= 1'b0;
        wr_data   <= 22'h000000;
    end else begin
        wr_valid <= 1'b0;
        if (ce_high || !port_live) begin
            bit_cnt   <= 3'h0;
            byte_cnt  <= 8'h00;
            shift_out <= 8'h00;
        end else begin
            if (sck_rise) begin
                shift_in <= next_shift_in;
                bit_cnt  <= bit_cnt + 3'h1;
            end
            if (byte_done) begin
                byte_cnt <= byte_cnt + 8'h01;
                if (byte_cnt == 8'h00) begin
                    header <= next_shift_in;
                end else if (!is_read && byte_cnt[0]) begin
                    // odd payload bytes are the high half of a word
                    data_hi  <= next_shift_in;
                end else if (!is_read && wr_ready) begin
                    // a word left unpaired at enable rise is dropped
                    wr_valid <= 1'b1;
                    wr_data  <= {header[`ADDR_W-1:0], data_hi,
                                 next_shift_in};
                end
            end
            if (sck_fall) begin
                if (bit_cnt == 3'h0 && byte_cnt != 8'h00 && is_read)
                    shift_out <= byte_cnt[0] ? rd_word[15:8] : rd_word[7:0];
                else
                    shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// buffer between serial port and core registers

wire        buf_valid;
wire [21:0] buf_data;

word_buffer #(
    .WIDTH     (22)
) u_word_buffer (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (buf_valid),
    .out_ready (1'b1),
    .out_data  (buf_data)
);

////////////////////////////////////////////////////////////////////////////
// internal registers on the core clock

reg  [15:0] clock_output_pin_reg;
reg  [15:0] timer_cmp;
reg  [15:0] doze_timer;
reg  [2:0]  cmd;
reg         cmd_valid;
wire [5:0]  wr_addr = buf_data[21:16];
wire [15:0] wr_word = buf_data[15:0];

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        clock_output_pin_reg  <= `CLOCK_OUTPUT_PIN_RST;
        timer_cmp <= 16'h0000;
        tx_power  <= `POWER_RST;
        cmd       <= 3'h0;
        cmd_valid <= 1'b0;
    end else begin
        cmd_valid <= 1'b0;
        if (buf_valid) begin
            case (wr_addr)
                `ADDR_CLOCK_OUTPUT_PIN:  clock_output_pin_reg  <= wr_word;
                `ADDR_TIMER: timer_cmp <= wr_word;
                `ADDR_POWER: tx_power  <= wr_word;
                `ADDR_MODE: begin
                    cmd       <= wr_word[2:0];
                    cmd_valid <= 1'b1;
                end
                default: ;
            endcase
        end
    end
end

always @* begin
    case (header[`ADDR_W-1:0])
        `ADDR_CLOCK_OUTPUT_PIN:   rd_word = clock_output_pin_reg;
        `ADDR_TIMER:  rd_word = timer_cmp;
        `ADDR_POWER:  rd_word = tx_power;
        `ADDR_STATUS: rd_word = {13'h0000, mode};
        default:      rd_word = 16'h0000;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// mode controller

reg  [21:0] wait_cnt;
reg  [2:0]  target;
wire [2:0]  clock_output_pin_sel  = clock_output_pin_reg[`CLOCK_OUTPUT_PIN_SEL_LSB+2:`CLOCK_OUTPUT_PIN_SEL_LSB];
wire        clock_output_pin_slow = (clock_output_pin_sel >= `CLOCK_OUTPUT_PIN_SEL_1MHZ);
wire        timer_hit = (doze_timer == timer_cmp);

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        mode       <= `MODE_OFF;
        target     <= `MODE_IDLE;
        wait_cnt   <= 22'h000000;
        doze_timer <= 16'h0000;
    end else if (held_in_reset) begin
        mode     <= `MODE_OFF;
        wait_cnt <= 22'h000000;
    end else begin
        doze_timer <= (mode == `MODE_DOZE) ? doze_timer + 16'h0001
                                           : 16'h0000;
        case (mode)
            `MODE_OFF: begin
                // shortest legal wait, counted from release of the pin
                wait_cnt <= wait_cnt + 22'h000001;
                if (wait_cnt == OFF_CYCLES[21:0] - 22'h000001) begin
                    mode     <= `MODE_IDLE;
                    wait_cnt <= 22'h000000;
                end
            end
            `MODE_HIB: begin
                // the wait only starts once the wake pin is seen low
                if (wait_cnt != 22'h000000)
                    wait_cnt <= wait_cnt + 22'h000001;
                else if (wake_now)
                    wait_cnt <= 22'h000001;
                if (wait_cnt == HIB_CYCLES[21:0]) begin
                    mode     <= `MODE_IDLE;
                    wait_cnt <= 22'h000000;
                end
            end
            `MODE_DOZE: begin
                if (wait_cnt != 22'h000000)
                    wait_cnt <= wait_cnt + 22'h000001;
                else if (wake_now || timer_hit)
                    wait_cnt <= 22'h000001;
                if (wait_cnt == DOZE_CYCLES[21:0]) begin
                    mode     <= `MODE_IDLE;
                    wait_cnt <= 22'h000000;
                end
            end
            `MODE_IDLE: begin
                if (cmd_valid) begin
                    case (cmd)
                        `CMD_HIB:  mode <= `MODE_HIB;
                        `CMD_DOZE: mode <= `MODE_DOZE;
                        `CMD_RX, `CMD_TX: begin
                            target   <= cmd;
                            wait_cnt <= 22'h000001;
                        end
                        default: ;
                    endcase
                end else if (wait_cnt != 22'h000000) begin
                    wait_cnt <= wait_cnt + 22'h000001;
                    if (wait_cnt == RXTX_CYCLES[21:0]) begin
                        mode     <= target;
                        wait_cnt <= 22'h000000;
                    end
                end
            end
            `MODE_RX, `MODE_TX: begin
                if (cmd_valid && cmd == `CMD_IDLE)
                    mode <= `MODE_IDLE;
            end
            default: mode <= `MODE_OFF;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// clock output divider and pin drivers

reg [7:0] clock_output_pin_div;
wire      clock_output_pin_run = (mode == `MODE_IDLE) || (mode == `MODE_RX) ||
                     (mode == `MODE_TX) ||
                     ((mode == `MODE_DOZE) && clock_output_pin_reg[`CLOCK_OUTPUT_PIN_EN_BIT] &&
                      clock_output_pin_slow);

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        clock_output_pin_div         <= 8'h00;
        clock_output_pin <= 1'b0;
        clock_output_oe  <= 1'b0;
        miso             <= 1'b0;
        miso_oe          <= 1'b0;
        irq_n_out        <= 1'b1;
        irq_oe           <= 1'b0;
        osc_on           <= 1'b0;
        rx_on            <= 1'b0;
        tx_on            <= 1'b0;
    end else begin
        // divide by a power of two chosen by the select field
        clock_output_pin_div         <= clock_output_pin_run ? clock_output_pin_div + 8'h01 : 8'h00;
        clock_output_pin <= clock_output_pin_run & clock_output_pin_div[clock_output_pin_sel];
        // all pins released in Off
        clock_output_oe  <= (mode != `MODE_OFF);
        irq_oe           <= 1'b0;
        irq_n_out        <= 1'b1;
        // slave only: of the serial port lines only the data output is ever driven
        miso             <= shift_out[7];
        miso_oe          <= !ce_high && port_live &&
                            (mode != `MODE_OFF);
        osc_on           <= (mode != `MODE_OFF) && (mode != `MODE_HIB);
        rx_on            <= (mode == `MODE_RX);
        tx_on            <= (mode == `MODE_TX);
    end
end

endmodule // xcvr_ctrl

// [sim/spi_host_model.sv]
// host-side serial master model for the transceiver port
`timescale 1ns/1ps
module spi_host_model #(
    parameter HALF = 8
) (
    // pacing clock
    input  wire logic mclk,
    // serial port
    output logic      serial_clock_in,
    output logic      chip_enable_n,
    output logic      mosi,
    input  wire logic miso
);
    ////////////////////////////////////////////////////////////////////////
    // half period of 8 mclk keeps the link inside the 50 ns pulse minimum
    initial begin
        serial_clock_in = 1'b0;
        chip_enable_n   = 1'b1;
        mosi            = 1'b0;
    end

    // change on the low phase, sample on the rise
    task automatic bit_cyc(input logic b, output logic r);
        mosi <= b;
        repeat (HALF) @(posedge mclk);
        serial_clock_in <= 1'b1;
        r = miso;
        repeat (HALF) @(posedge mclk);
        serial_clock_in <= 1'b0;
    endtask

    // header then one two-byte payload, one direction only
    task automatic xfer(input logic [7:0] hdr, input logic [15:0] wd,
                        output logic [15:0] rd);
        logic [23:0] sh;
        logic        r;
        sh = {hdr, wd};
        @(posedge mclk);
        chip_enable_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            // no pull on this line: a read leaves it toggling
            bit_cyc(hdr[7] && i < 16 ? ~mosi : sh[i], r);
            if (i < 16) rd[i] = r;
        end
        repeat (HALF) @(posedge mclk);
        chip_enable_n <= 1'b1;
        repeat (2 * HALF) @(posedge mclk);
    endtask
endmodule // spi_host_model

// [sim/xcvr_ctrl_assertions.sv]
// concurrent checks on the mode controller ports
`timescale 1ns/1ps
module xcvr_ctrl_assertions #(
    parameter OFF_CYCLES  = 40,
    parameter HIB_CYCLES  = 60,
    parameter DOZE_CYCLES = 50,
    parameter RXTX_CYCLES = 30
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // pins
    input  wire logic       reset_pin_n,
    input  wire logic       wake_request_n,
    input  wire logic       chip_enable_n,
    // outputs
    input  wire logic       miso_oe,
    input  wire logic       clock_output_oe,
    input  wire logic       irq_oe,
    input  wire logic       osc_on,
    input  wire logic       rx_on,
    input  wire logic       tx_on,
    input  wire logic [2:0] mode
);
    localparam int OFF_LO  = OFF_CYCLES - 2;
    localparam int HIB_HI  = HIB_CYCLES + 16;
    localparam int DOZE_HI = DOZE_CYCLES + 16;
    localparam int RX_LO   = RXTX_CYCLES - 16;
    localparam int RX_HI   = RXTX_CYCLES + 32;
    logic [15:0] since_cs;

    ////////////////////////////////////////////////////////////////////////
    // cycles since enable was last low, saturating
    always @(posedge mclk or posedge rst) begin
        if (rst) since_cs <= 16'hffff;
        else if (!chip_enable_n) since_cs <= 16'h0000;
        else if (since_cs != 16'hffff) since_cs <= since_cs + 16'h0001;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence off_wait;
        (mode == 3'h0) throughout (##[OFF_LO:OFF_LO] 1'b1);
    endsequence
    sequence hib_to_idle;
        ##[1:HIB_HI] mode == 3'h3;
    endsequence
    sequence doze_to_idle;
        ##[1:DOZE_HI] mode == 3'h3;
    endsequence

    chk_off_to_idle: assert property (
        $rose(reset_pin_n) |-> off_wait ##[1:24] mode == 3'h3)
        else $error("off to idle timing wrong");
    chk_off_released: assert property (
        !reset_pin_n [*6] |-> mode == 3'h0 && !miso_oe
            && !clock_output_oe && !irq_oe)
        else $error("outputs driven while held off");
    chk_sleep_by_cmd: assert property (
        $changed(mode) && (mode == 3'h1 || mode == 3'h2)
            |-> since_cs < 16'h0040)
        else $error("sleep entered without a command");
    chk_hib_quiet: assert property (
        mode == 3'h1 [*2] |-> !osc_on && !miso_oe)
        else $error("hibernate left oscillator or data on");
    chk_hib_wake: assert property (
        $fell(wake_request_n) && mode == 3'h1 |-> hib_to_idle)
        else $error("hibernate wake too slow");
    chk_doze_wake: assert property (
        $fell(wake_request_n) && mode == 3'h2 |-> doze_to_idle)
        else $error("doze wake too slow");
    chk_idle_outputs: assert property (
        mode == 3'h3 [*2] |-> osc_on && clock_output_oe && !rx_on && !tx_on)
        else $error("idle outputs wrong");
    chk_rx_mode_on: assert property (
        mode == 3'h4 [*2] |-> rx_on && !tx_on && osc_on)
        else $error("receive mode without receiver");
    chk_rxtx_time: assert property (
        $rose(rx_on) || $rose(tx_on) |-> since_cs >= RX_LO
            && since_cs <= RX_HI)
        else $error("radio turn-on time wrong");
    chk_miso_release: assert property (
        chip_enable_n [*4] |-> !miso_oe)
        else $error("data out driven while deselected");
endmodule // xcvr_ctrl_assertions

bind xcvr_ctrl xcvr_ctrl_assertions #(
    .OFF_CYCLES(OFF_CYCLES), .HIB_CYCLES(HIB_CYCLES),
    .DOZE_CYCLES(DOZE_CYCLES), .RXTX_CYCLES(RXTX_CYCLES)
) chk_u (.mclk, .rst, .reset_pin_n, .wake_request_n, .chip_enable_n,
    .miso_oe, .clock_output_oe, .irq_oe, .osc_on, .rx_on, .tx_on, .mode);

// [sim/testbench.sv]
// self-checking bench for the mode controller and serial slave
`timescale 1ns/1ps
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    logic        mclk, rst, reset_pin_n, wake_request_n;
    wire         serial_clock_in, chip_enable_n, mosi, miso, miso_oe;
    wire         clock_output_pin, clock_output_oe, irq_n_out, irq_oe;
    wire         osc_on, rx_on, tx_on;
    wire  [15:0] tx_power;
    wire  [2:0]  mode;
    int          fail_count, n_tests;

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // short counts keep the run brief
    xcvr_ctrl #(.OFF_CYCLES(40), .HIB_CYCLES(60), .DOZE_CYCLES(50),
        .RXTX_CYCLES(30)) dut_u (.mclk, .rst, .reset_pin_n,
        .wake_request_n, .serial_clock_in, .chip_enable_n, .mosi, .miso,
        .miso_oe, .clock_output_pin, .clock_output_oe, .irq_n_out,
        .irq_oe, .osc_on, .rx_on, .tx_on, .tx_power, .mode);
    spi_host_model host_u (.mclk, .serial_clock_in, .chip_enable_n,
        .mosi, .miso);

    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        logic [15:0] r;
        host_u.xfer({2'b00, a}, v, r);
        @(negedge mclk);
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] v);
        host_u.xfer({2'b10, a}, 16'h0000, v);
        @(negedge mclk);
    endtask
    task automatic wait_mode(input logic [2:0] m, output int n);
        for (n = 0; n < 400 && mode !== m; n++) @(negedge mclk);
        // radio and pin enables follow mode one cycle later
        @(negedge mclk);
    endtask
    task automatic count_edges(input int c, output int e);
        logic p;
        e = 0;
        p = clock_output_pin;
        repeat (c) begin
            @(negedge mclk);
            if (clock_output_pin !== p) e++;
            p = clock_output_pin;
        end
    endtask

    task automatic t_off;
        int n;
        `CHECK({mode, miso_oe, clock_output_oe, irq_oe}, 6'h00)
        @(posedge mclk) reset_pin_n <= 1'b1;
        wait_mode(3'h3, n);
        `CHECK(n >= 40 && n <= 60, 1'b1)
        `CHECK({osc_on, clock_output_oe, irq_oe}, 3'b110)
        `CHECK(tx_power, 16'h00bc)
        $display("test off_to_idle done");
    endtask
    task automatic t_power;
        logic [15:0] v;
        wr(6'h0c, 16'h00ff);
        `CHECK(tx_power, 16'h00ff)
        rd(6'h0c, v);
        `CHECK(v, 16'h00ff)
        rd(6'h10, v);
        `CHECK(v, 16'h0003)
        wr(6'h0c, 16'h00bc);
        `CHECK(tx_power, 16'h00bc)
        $display("test power done");
    endtask
    task automatic t_rxtx;
        int n;
        wr(6'h01, 16'h0004);
        wait_mode(3'h4, n);
        `CHECK({rx_on, tx_on, osc_on}, 3'b101)
        wr(6'h01, 16'h0003);
        wait_mode(3'h3, n);
        wr(6'h01, 16'h0005);
        wait_mode(3'h5, n);
        `CHECK({rx_on, tx_on, osc_on}, 3'b011)
        wr(6'h01, 16'h0003);
        wait_mode(3'h3, n);
        `CHECK(mode, 3'h3)
        $display("test rx_tx done");
    endtask
    task automatic t_hib;
        int n;
        wr(6'h01, 16'h0001);
        `CHECK({mode, osc_on}, 4'h2)
        wr(6'h0c, 16'h00ff);
        @(posedge mclk) wake_request_n <= 1'b0;
        wait_mode(3'h3, n);
        `CHECK(n >= 60 && n <= 80, 1'b1)
        `CHECK(tx_power, 16'h00bc)
        @(posedge mclk) wake_request_n <= 1'b1;
        $display("test hibernate done");
    endtask
    task automatic t_doze;
        int n, e;
        wr(6'h07, 16'h0000);
        wr(6'h08, 16'hffff);
        wr(6'h01, 16'h0002);
        `CHECK(mode, 3'h2)
        count_edges(24, e);
        `CHECK(e == 0, 1'b1)
        @(posedge mclk) wake_request_n <= 1'b0;
        wait_mode(3'h3, n);
        `CHECK(n >= 50 && n <= 70, 1'b1)
        @(posedge mclk) wake_request_n <= 1'b1;
        wr(6'h07, 16'h0203);
        wr(6'h08, 16'h0010);
        wr(6'h01, 16'h0002);
        count_edges(16, e);
        `CHECK(e > 0, 1'b1)
        wait_mode(3'h3, n);
        `CHECK(mode, 3'h3)
        $display("test doze done");
    endtask

    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        reset_pin_n = 1'b0;
        wake_request_n = 1'b1;
        fail_count = 0;
        n_tests = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(negedge mclk);
        t_off;
        t_power;
        t_rxtx;
        t_hib;
        t_doze;
        @(posedge mclk) reset_pin_n <= 1'b0;
        repeat (8) @(negedge mclk);
        t_off;
        summarize;
    end
    // about three and a half times the expected run
    initial begin
        #200000;
        fail_count++;
        summarize;
    end
endmodule // testbench
